/* File: lpm_pkg.sv */
// Shared constants and types for the low-power mode sequencer
package lpm_pkg;

   // Clock rates in Hz
   localparam int unsigned LPM_MCLK_HZ = 100_000_000;
   localparam int unsigned LPM_HSI_HZ = 16_000_000;
   localparam int unsigned LPM_AWU_CLK_HZ = 128_000;

   // Master cycles per auto-wakeup tick, rounded down
   localparam int unsigned LPM_AWU_PRESC_CYC = LPM_MCLK_HZ / LPM_AWU_CLK_HZ;
   localparam int LPM_PRESC_W = 10;
   localparam logic [LPM_PRESC_W-1:0] LPM_PRESC_LAST = LPM_PRESC_W'(LPM_AWU_PRESC_CYC - 1);
   localparam logic [LPM_PRESC_W-1:0] LPM_PRESC_RST = 10'h000;

   // Auto-wakeup interval counter
   localparam int LPM_AWU_W = 12;
   localparam logic [LPM_AWU_W-1:0] LPM_AWU_CNT_RST = 12'h000;

   // Internal oscillator divider: 0 /1, 1 /2, 2 /4, 3 /8
   localparam logic [1:0] LPM_DIV_RST = 2'h3;

   // Master clock sources
   typedef enum logic [1:0] {LPM_SRC_HSI, LPM_SRC_LSI, LPM_SRC_HSE} lpm_src_t;
   localparam lpm_src_t LPM_SRC_RST = LPM_SRC_HSI;

   // Sequencer modes
   typedef enum logic [1:0] {LPM_RUN, LPM_WAIT, LPM_AHALT, LPM_HALT} lpm_mode_t;
   localparam lpm_mode_t LPM_MODE_RST = LPM_RUN;

   // Source of the most recent wakeup
   typedef enum logic [2:0] {
      LPM_WAKE_NONE, LPM_WAKE_IRQ, LPM_WAKE_PIN, LPM_WAKE_PERIPH, LPM_WAKE_AWU
   } lpm_wake_t;
   localparam lpm_wake_t LPM_WAKE_RST = LPM_WAKE_NONE;

endpackage

/* File: lpm_awu_if.sv */
// Link between the mode sequencer and the auto-wakeup timer
`timescale 1ns/1ps
interface lpm_awu_if;
   import lpm_pkg::*;
   logic run;
   logic restart;
   logic [LPM_AWU_W-1:0] period;
   logic wake;
   modport seq (output run, output restart, output period, input wake);
   modport timer (input run, input restart, input period, output wake);
endinterface

/* File: lpm_awu_timer.sv */
// Auto-wakeup interval timer, ticking from a master clock prescaler
`timescale 1ns/1ps
module lpm_awu_timer
   import lpm_pkg::*;
(
   input wire logic mclk,
   input wire logic rst_n,
   lpm_awu_if.timer awu
);

   typedef struct packed {
      logic [LPM_PRESC_W-1:0] presc;
      logic [LPM_AWU_W-1:0] cnt;
      logic wake;
   } lpm_awu_st_t;

   localparam lpm_awu_st_t AWU_ST_RST = '{presc: LPM_PRESC_RST, cnt: LPM_AWU_CNT_RST, wake: 1'b0};

   lpm_awu_st_t s;
   lpm_awu_st_t next_s;
   logic [LPM_AWU_W:0] cnt_inc;

   // Count only while running; a restart always wins so each entry starts at zero
   always_comb begin
      next_s = s;
      next_s.wake = 1'b0;
      cnt_inc = {1'b0, s.cnt} + 13'h0001;
      if (awu.restart) begin
         next_s.presc = LPM_PRESC_RST;  // see RQ22
         next_s.cnt = LPM_AWU_CNT_RST;
      end else if (awu.run) begin
         if (s.presc == LPM_PRESC_LAST) begin
            next_s.presc = LPM_PRESC_RST;
            // Period zero behaves as one tick rather than never firing
            if (cnt_inc >= {1'b0, awu.period}) begin
               next_s.cnt = LPM_AWU_CNT_RST;
               next_s.wake = 1'b1;  // see RQ13
            end else begin
               next_s.cnt = cnt_inc[LPM_AWU_W-1:0];
            end
         end else begin
            next_s.presc = s.presc + 10'h001;
         end
      end
   end

   // State register
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         s <= AWU_ST_RST;
      end else begin
         s <= next_s;
      end
   end

   assign awu.wake = s.wake;

endmodule

/* File: lpm_sequencer.sv */
// Low-power mode sequencer: run, wait, active-halt and full halt control
//
// Operation
// RQ1 - Reset brings everything up in run mode
// RQ2 - Reset clock is internal oscillator divided by eight
// RQ3 - Wait stops only the CPU clock
// RQ4 - Entering wait forces interrupts enabled
// RQ5 - Any interrupt or reset wakes wait fastest
// RQ6 - Activation level set: ISR returns to wait
// RQ7 - Clearing activation level resumes the main program
// RQ8 - Activation level ignored for both halt modes
// RQ9 - Software enables auto-wakeup before halt instruction
// RQ10 - Halt phase keeps only auto-wakeup and its oscillator
// RQ11 - Active watchdog keeps running in active-halt
// RQ12 - Auto-wakeup counts only during the halt phase
// RQ13 - Auto-wakeup event returns device to run
// RQ14 - Halt phase uses selected regulator and flash state
// RQ15 - Low-power regulator in use turns main off
// RQ16 - Enabled watchdog turns halt into active-halt
// RQ17 - Watchdog-forced phase without auto-wakeup needs reset; the pin or a peripheral interrupt also ends it here
// RQ18 - Full-halt wake sources also wake active-halt
// RQ19 - Full halt stops CPU, oscillators, peripheral clocks
// RQ20 - Low-speed master clock needs its option bit
// RQ21 - Full halt always uses the low-power regulator
// RQ22 - Auto-wakeup counters restart from zero each entry
// RQ23 - Pin, qualifying peripheral interrupt or reset wake halt
// RQ24 - Four modes; every wakeup returns to run
`timescale 1ns/1ps
module lpm_sequencer
   import lpm_pkg::*;
(
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic wait_for_interrupt_instruction,
   input wire logic halt_instruction,
   input wire logic isr_return,
   input wire logic activation_level_bit,
   input wire logic irq_request,
   input wire logic ext_pin_irq,
   input wire logic halt_periph_irq,
   input wire logic awu_enable,
   input wire logic awu_src_lsi,
   input wire logic [LPM_AWU_W-1:0] awu_period,
   input wire logic independent_watchdog_timer_enabled,
   input wire logic lp_regulator_sel,
   input wire logic flash_pd_sel,
   input wire logic flash_on_in_halt,
   input wire logic low_speed_master_clock_option,
   input wire logic clk_sel_wr,
   input wire logic [1:0] clk_sel_req,
   input wire logic osc_div_wr,
   input wire logic [1:0] osc_div_wdata,
   output lpm_mode_t mode,
   output logic cpu_clk_en,
   output logic periph_clk_en,
   output logic irq_ctrl_clk_en,
   output logic irq_enable_force,
   output logic skip_context,
   output logic main_regulator_on,
   output logic low_power_regulator_on,
   output logic flash_on,
   output logic hsi_on,
   output logic hse_on,
   output logic lsi_on,
   output logic independent_watchdog_timer_clk_en,
   output logic awu_running,
   output logic awu_wakeup,
   output logic watchdog_forced_halt,
   output lpm_src_t master_clk_sel,
   output logic [1:0] internal_osc_divider,
   output lpm_wake_t wake_cause
);

   // Entire module state, registered in one place
   typedef struct packed {
      // Mode and clock gates
      lpm_mode_t mode;
      logic cpu_clk_en;
      logic periph_clk_en;
      logic irq_ctrl_clk_en;
      // Interrupt-side strobe and flag
      logic irq_enable_force;
      logic skip_context;
      // Supplies and oscillators
      logic main_regulator_on;
      logic low_power_regulator_on;
      logic flash_on;
      logic hsi_on;
      logic hse_on;
      logic lsi_on;
      logic independent_watchdog_timer_clk_en;
      // Timer control and status
      logic awu_run;
      logic awu_restart;
      logic awu_wakeup;
      logic wd_forced;
      // Clock setup and wake history
      lpm_src_t master_clk_sel;
      logic [1:0] osc_div;
      lpm_wake_t wake_cause;
      // Pin stages and agreed level
      logic [2:0] pin_sync;
      logic pin_lvl;
   } lpm_st_t;

   // Run mode with everything powered and the reset clock choice
   localparam lpm_st_t ST_RST = '{
      mode: LPM_MODE_RST,
      cpu_clk_en: 1'b1,
      periph_clk_en: 1'b1,
      irq_ctrl_clk_en: 1'b1,
      irq_enable_force: 1'b0,
      skip_context: 1'b0,
      main_regulator_on: 1'b1,
      low_power_regulator_on: 1'b0,
      flash_on: 1'b1,
      hsi_on: 1'b1,
      hse_on: 1'b1,
      lsi_on: 1'b1,
      independent_watchdog_timer_clk_en: 1'b1,
      awu_run: 1'b0,
      awu_restart: 1'b0,
      awu_wakeup: 1'b0,
      wd_forced: 1'b0,
      master_clk_sel: LPM_SRC_RST,
      osc_div: LPM_DIV_RST,
      wake_cause: LPM_WAKE_RST,
      // Idles low like the pin, so no false wake after reset
      pin_sync: 3'h0,
      pin_lvl: 1'b0
   };

   lpm_st_t s;
   lpm_st_t next_s;
   logic halt_wake;
   logic awu_hit;
   logic run_like;
   lpm_awu_if awu_bus();

   // Interval timer; it only ever sees mclk, gated by the run request
   lpm_awu_timer u_awu (
      .mclk(mclk),
      .rst_n(rst_n),
      .awu(awu_bus)
   );

   // Timer run and restart straight from the state register, period from the input
   assign awu_bus.run = s.awu_run;
   assign awu_bus.restart = s.awu_restart;
   assign awu_bus.period = awu_period;

   // Wake terms shared by both halt flavours
   assign halt_wake = s.pin_lvl | halt_periph_irq;  // see RQ23
   // Without auto-wakeup enabled the timer can never end a halt phase
   assign awu_hit = awu_bus.wake & awu_enable;  // see RQ17

   always_comb begin
      next_s = s;
      next_s.irq_enable_force = 1'b0;
      next_s.awu_restart = 1'b0;
      next_s.awu_wakeup = 1'b0;

      // Pin crossing: a change counts once stages two and three agree
      next_s.pin_sync = {s.pin_sync[1:0], ext_pin_irq};
      if (s.pin_sync[1] == s.pin_sync[2]) begin
         next_s.pin_lvl = s.pin_sync[2];
      end

      // Mode transitions
      unique case (s.mode)
         LPM_RUN: begin
            if (halt_instruction) begin
               next_s.skip_context = 1'b0;  // see RQ8
               // Relies on software having set up the timer first, see RQ9
               if (independent_watchdog_timer_enabled || awu_enable) begin
                  next_s.mode = LPM_AHALT;  // see RQ16
                  next_s.awu_restart = 1'b1;  // see RQ22
                  next_s.wd_forced = independent_watchdog_timer_enabled & ~awu_enable;  // see RQ17
               end else begin
                  next_s.mode = LPM_HALT;
                  next_s.wd_forced = 1'b0;
               end
            end else if (wait_for_interrupt_instruction) begin
               next_s.mode = LPM_WAIT;
               next_s.irq_enable_force = 1'b1;  // see RQ4
               next_s.skip_context = activation_level_bit;  // see RQ6
            end else if (isr_return && s.skip_context) begin
               if (activation_level_bit) begin
                  // Straight back to wait, no context restore
                  next_s.mode = LPM_WAIT;  // see RQ6
                  next_s.irq_enable_force = 1'b1;  // see RQ4
               end else begin
                  next_s.skip_context = 1'b0;  // see RQ7
               end
            end
         end
         LPM_WAIT: begin
            // Single-cycle exit keeps this the fastest wake path
            if (irq_request) begin
               next_s.mode = LPM_RUN;  // see RQ5
               next_s.wake_cause = LPM_WAKE_IRQ;
            end else if (s.pin_lvl) begin
               next_s.mode = LPM_RUN;  // see RQ5
               next_s.wake_cause = LPM_WAKE_PIN;
            end else if (halt_periph_irq) begin
               next_s.mode = LPM_RUN;  // see RQ5
               next_s.wake_cause = LPM_WAKE_PERIPH;
            end
         end
         LPM_AHALT: begin
            if (awu_hit) begin
               next_s.mode = LPM_RUN;  // see RQ13
               next_s.awu_wakeup = 1'b1;
               next_s.wake_cause = LPM_WAKE_AWU;
            end else if (halt_wake) begin
               next_s.mode = LPM_RUN;  // see RQ18
               next_s.wake_cause = s.pin_lvl ? LPM_WAKE_PIN : LPM_WAKE_PERIPH;
            end
         end
         LPM_HALT: begin
            if (halt_wake) begin
               next_s.mode = LPM_RUN;  // see RQ23
               next_s.wake_cause = s.pin_lvl ? LPM_WAKE_PIN : LPM_WAKE_PERIPH;
            end
         end
      endcase

      // Leaving the halt phase clears the forced flag
      if (next_s.mode == LPM_RUN) begin
         next_s.wd_forced = 1'b0;  // see RQ24
      end

      // Clock gates follow the mode being entered
      run_like = (next_s.mode == LPM_RUN) || (next_s.mode == LPM_WAIT);
      next_s.cpu_clk_en = next_s.mode == LPM_RUN;  // see RQ3
      next_s.periph_clk_en = run_like;  // see RQ3
      next_s.irq_ctrl_clk_en = run_like;  // see RQ3
      next_s.awu_run = next_s.mode == LPM_AHALT;  // see RQ12

      // Oscillators: only the timer clock and, with the watchdog on, the low-speed oscillator survive a halt phase
      unique case (next_s.mode)
         LPM_RUN, LPM_WAIT: begin
            next_s.hsi_on = 1'b1;
            next_s.hse_on = 1'b1;
            next_s.lsi_on = 1'b1;
            next_s.independent_watchdog_timer_clk_en = 1'b1;
         end
         LPM_AHALT: begin
            next_s.hsi_on = 1'b0;  // see RQ10
            next_s.hse_on = awu_enable & ~awu_src_lsi;  // see RQ10
            // Watchdog runs from the low-speed oscillator too
            next_s.lsi_on = (awu_enable & awu_src_lsi) | independent_watchdog_timer_enabled;  // see RQ11
            next_s.independent_watchdog_timer_clk_en = independent_watchdog_timer_enabled;  // see RQ11
         end
         LPM_HALT: begin
            next_s.hsi_on = 1'b0;  // see RQ19
            next_s.hse_on = 1'b0;  // see RQ19
            next_s.lsi_on = 1'b0;  // see RQ19
            next_s.independent_watchdog_timer_clk_en = 1'b0;
         end
      endcase

      // Regulator and flash state per mode
      unique case (next_s.mode)
         LPM_RUN, LPM_WAIT: begin
            next_s.low_power_regulator_on = 1'b0;
            next_s.flash_on = 1'b1;
         end
         LPM_AHALT: begin
            next_s.low_power_regulator_on = lp_regulator_sel;  // see RQ14
            next_s.flash_on = ~flash_pd_sel;  // see RQ14
         end
         LPM_HALT: begin
            next_s.low_power_regulator_on = 1'b1;  // see RQ21
            next_s.flash_on = flash_on_in_halt;
         end
      endcase
      // Never both regulators at once
      next_s.main_regulator_on = ~next_s.low_power_regulator_on;  // see RQ15

      // Clock configuration; writes only land while the CPU runs
      if (s.mode == LPM_RUN) begin
         if (osc_div_wr) begin
            next_s.osc_div = osc_div_wdata;
         end
         if (clk_sel_wr) begin
            // Unknown codes and a barred low-speed request keep the current source
            if (clk_sel_req == 2'h0) begin
               next_s.master_clk_sel = LPM_SRC_HSI;
            end else if (clk_sel_req == 2'h2) begin
               next_s.master_clk_sel = LPM_SRC_HSE;
            end else if (clk_sel_req == 2'h1 && low_speed_master_clock_option) begin
               next_s.master_clk_sel = LPM_SRC_LSI;  // see RQ20
            end
         end
      end
   end

   // State register; reset lands in run with the divided internal clock
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         s <= ST_RST;  // see RQ1
      end else begin
         s <= next_s;
      end
   end

   // Outputs straight from the state register
   assign mode = s.mode;

   // Clock gates
   assign cpu_clk_en = s.cpu_clk_en;
   assign periph_clk_en = s.periph_clk_en;
   assign irq_ctrl_clk_en = s.irq_ctrl_clk_en;

   // Interrupt side
   assign irq_enable_force = s.irq_enable_force;
   assign skip_context = s.skip_context;

   // Supplies
   assign main_regulator_on = s.main_regulator_on;
   assign low_power_regulator_on = s.low_power_regulator_on;
   assign flash_on = s.flash_on;

   // Oscillators
   assign hsi_on = s.hsi_on;
   assign hse_on = s.hse_on;
   assign lsi_on = s.lsi_on;
   assign independent_watchdog_timer_clk_en = s.independent_watchdog_timer_clk_en;

   // Timer status
   assign awu_running = s.awu_run;
   assign awu_wakeup = s.awu_wakeup;
   assign watchdog_forced_halt = s.wd_forced;

   // Clock setup and wake history
   assign master_clk_sel = s.master_clk_sel;
   assign internal_osc_divider = s.osc_div;  // see RQ2
   assign wake_cause = s.wake_cause;

endmodule

/* File: lpm_sequencer_asserts.sv */
// Port-level checks for the low-power mode sequencer
`timescale 1ns/1ps
module lpm_sequencer_asserts
   import lpm_pkg::*;
(
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic halt_instruction,
   input wire logic irq_request,
   input wire logic ext_pin_irq,
   input wire logic halt_periph_irq,
   input wire logic awu_enable,
   input wire logic independent_watchdog_timer_enabled,
   input wire logic lp_regulator_sel,
   input wire logic flash_pd_sel,
   input wire lpm_mode_t mode,
   input wire logic cpu_clk_en,
   input wire logic periph_clk_en,
   input wire logic irq_ctrl_clk_en,
   input wire logic irq_enable_force,
   input wire logic skip_context,
   input wire logic main_regulator_on,
   input wire logic low_power_regulator_on,
   input wire logic flash_on,
   input wire logic hsi_on,
   input wire logic hse_on,
   input wire logic lsi_on,
   input wire logic awu_running,
   input wire logic awu_wakeup,
   input wire logic watchdog_forced_halt,
   input wire lpm_wake_t wake_cause
);
   logic [4:0] pin_hist;

   // Recent pin history: a pin wake lands several edges after the pin moves
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         pin_hist <= 5'h00;
      end else begin
         pin_hist <= {pin_hist[3:0], ext_pin_irq};
      end
   end

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);

   a_wait_cpu_off: assert property (mode == LPM_WAIT |-> !cpu_clk_en && periph_clk_en && irq_ctrl_clk_en
      && main_regulator_on && flash_on) else $error("wait mode gates more than the cpu");
   a_wait_irq_force: assert property (mode == LPM_WAIT && $past(mode) != LPM_WAIT |-> irq_enable_force)
      else $error("wait entry without interrupt enable");
   a_wait_irq_wake: assert property (mode == LPM_WAIT && irq_request |=> mode == LPM_RUN)
      else $error("interrupt did not end wait");
   a_lp_main_off: assert property (low_power_regulator_on |-> !main_regulator_on)
      else $error("both regulators on");
   a_halt_all_off: assert property (mode == LPM_HALT |-> !cpu_clk_en && !periph_clk_en && !hsi_on && !hse_on
      && !lsi_on && low_power_regulator_on) else $error("full halt left something running");
   a_ahalt_reg_sel: assert property (mode == LPM_AHALT |-> low_power_regulator_on == lp_regulator_sel
      && flash_on == !flash_pd_sel) else $error("halt phase ignores selects");
   a_independent_watchdog_timer_forces: assert property (mode == LPM_RUN && halt_instruction && independent_watchdog_timer_enabled && !awu_enable
      |=> mode == LPM_AHALT && watchdog_forced_halt) else $error("watchdog halt not forced");
   a_forced_stays: assert property (mode == LPM_AHALT && watchdog_forced_halt && !awu_enable && !irq_request
      && !halt_periph_irq && !ext_pin_irq && pin_hist == 5'h00 |=> mode == LPM_AHALT)
      else $error("forced halt woke on its own");
   a_awu_wake_run: assert property (awu_wakeup |-> mode == LPM_RUN && wake_cause == LPM_WAKE_AWU)
      else $error("timer wake not in run");
   a_awu_only_ahalt: assert property (mode != LPM_AHALT |-> !awu_running)
      else $error("timer runs outside halt phase");
   a_al_wait_only: assert property (mode == LPM_HALT || mode == LPM_AHALT |-> !skip_context)
      else $error("context skip in halt");
   a_halt_wake: assert property (mode == LPM_HALT && halt_periph_irq |=> mode == LPM_RUN)
      else $error("peripheral irq did not end halt");

   cover property (awu_wakeup);
   cover property (mode == LPM_HALT ##1 mode == LPM_RUN);
   cover property (watchdog_forced_halt && mode == LPM_AHALT);
endmodule

bind lpm_sequencer lpm_sequencer_asserts u_chk (.mclk, .rst_n, .halt_instruction, .irq_request, .ext_pin_irq,
   .halt_periph_irq, .awu_enable, .independent_watchdog_timer_enabled, .lp_regulator_sel, .flash_pd_sel, .mode, .cpu_clk_en,
   .periph_clk_en, .irq_ctrl_clk_en, .irq_enable_force, .skip_context, .main_regulator_on,
   .low_power_regulator_on, .flash_on, .hsi_on, .hse_on, .lsi_on, .awu_running, .awu_wakeup,
   .watchdog_forced_halt, .wake_cause);

/* File: lpm_cpu_model.sv */
// Behavioural CPU core issuing wait, halt and interrupt-return instructions
`timescale 1ns/1ps
module lpm_cpu_model
   import lpm_pkg::*;
(
   input wire logic mclk,
   input wire lpm_mode_t mode,
   output logic wait_for_interrupt_instruction,
   output logic halt_instruction,
   output logic isr_return,
   output logic activation_level_bit
);
   initial begin
      wait_for_interrupt_instruction = 1'b0;
      halt_instruction = 1'b0;
      isr_return = 1'b0;
      activation_level_bit = 1'b0;
   end

   // Strobe kind 0 wait, 1 halt, 2 return; a stopped core executes nothing
   task automatic issue(input int kind, input int gap);
      int n;
      n = 0;
      repeat (gap + 1) @(posedge mclk);
      #1;
      while (mode !== LPM_RUN && n < 5000) begin
         @(posedge mclk);
         #1;
         n++;
      end
      wait_for_interrupt_instruction = (kind == 0);
      halt_instruction = (kind == 1);
      isr_return = (kind == 2);
      @(posedge mclk);
      #1;
      {wait_for_interrupt_instruction, halt_instruction, isr_return} = 3'h0;
   endtask

   // Routine decides between staying interrupt-only and resuming main code
   task automatic ret(input logic resume);
      if (resume) begin
         activation_level_bit = 1'b0;
      end
      issue(2, 0);
   endtask

   task automatic set_al(input logic v);
      activation_level_bit = v;
   endtask
endmodule

/* File: low_power_mode_control_bench.sv */
// Self-checking bench for the low-power mode sequencer
`timescale 1ns/1ps
module low_power_mode_control_bench;
   import lpm_pkg::*;
   logic mclk, rst_n, irq_request, ext_pin_irq, halt_periph_irq, awu_enable, awu_src_lsi, independent_watchdog_timer_enabled;
   logic lp_regulator_sel, flash_pd_sel, flash_on_in_halt, low_speed_master_clock_option, clk_sel_wr, osc_div_wr;
   logic wait_for_interrupt_instruction, halt_instruction, isr_return, activation_level_bit;
   logic [LPM_AWU_W-1:0] awu_period;
   logic [1:0] clk_sel_req, osc_div_wdata, internal_osc_divider;
   logic cpu_clk_en, periph_clk_en, irq_ctrl_clk_en, irq_enable_force, skip_context, main_regulator_on;
   logic low_power_regulator_on, flash_on, hsi_on, hse_on, lsi_on, independent_watchdog_timer_clk_en, awu_running, awu_wakeup;
   logic watchdog_forced_halt;
   lpm_mode_t mode;
   lpm_src_t master_clk_sel;
   lpm_wake_t wake_cause;
   int error_cnt = 0;
   int n_compared = 0;
   int n_force = 0;
   int n_wake = 0;
   int c;

   lpm_sequencer u_dut (.mclk, .rst_n, .wait_for_interrupt_instruction, .halt_instruction, .isr_return,
      .activation_level_bit, .irq_request, .ext_pin_irq, .halt_periph_irq, .awu_enable, .awu_src_lsi,
      .awu_period, .independent_watchdog_timer_enabled, .lp_regulator_sel, .flash_pd_sel, .flash_on_in_halt,
      .low_speed_master_clock_option, .clk_sel_wr, .clk_sel_req, .osc_div_wr, .osc_div_wdata, .mode,
      .cpu_clk_en, .periph_clk_en, .irq_ctrl_clk_en, .irq_enable_force, .skip_context, .main_regulator_on,
      .low_power_regulator_on, .flash_on, .hsi_on, .hse_on, .lsi_on, .independent_watchdog_timer_clk_en, .awu_running,
      .awu_wakeup, .watchdog_forced_halt, .master_clk_sel, .internal_osc_divider, .wake_cause);
   lpm_cpu_model u_cpu (.mclk, .mode, .wait_for_interrupt_instruction, .halt_instruction, .isr_return,
      .activation_level_bit);

   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end

   // One-cycle pulses are counted at the edge after they rise
   always @(posedge mclk) begin
      n_force += irq_enable_force;
      n_wake += awu_wakeup;
   end

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp) begin
         error_cnt++;
         $display("MISMATCH at %0t: saw %0h expected %0h", $time, seen, exp);
      end
   endtask

   task automatic step(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask

   // Bounded wait for a mode; cnt returns the edges it took
   task automatic wait_mode(input lpm_mode_t e, input int lim, output int cnt);
      cnt = 0;
      while (mode !== e && cnt < lim) begin
         step(1);
         cnt++;
      end
      check(8'(mode), 8'(e));
   endtask

   task automatic sel(input logic [1:0] code, input lpm_src_t e);
      clk_sel_req = code;
      clk_sel_wr = 1'b1;
      step(1);
      clk_sel_wr = 1'b0;
      check(8'(master_clk_sel), 8'(e));
      step(1);
   endtask

   task automatic wrap_up;
      if (error_cnt == 0 && n_compared > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge mclk);
      error_cnt++;
      wrap_up();
   end

   initial begin
      {rst_n, irq_request, ext_pin_irq, halt_periph_irq, awu_enable, awu_src_lsi, independent_watchdog_timer_enabled} = 7'h00;
      {lp_regulator_sel, flash_pd_sel, flash_on_in_halt, low_speed_master_clock_option} = 4'h0;
      {clk_sel_wr, osc_div_wr, clk_sel_req, osc_div_wdata} = 6'h00;
      awu_period = 12'h001;
      step(16);
      rst_n = 1'b1;
      check(8'(mode), 8'(LPM_RUN));
      check({cpu_clk_en, periph_clk_en, main_regulator_on, flash_on, hsi_on, hse_on, lsi_on, awu_running},
         8'hfe);
      check({master_clk_sel, 4'h0, internal_osc_divider}, 8'h03);
      // Clock selection, refused while the option is low
      sel(2'h1, LPM_SRC_HSI);
      low_speed_master_clock_option = 1'b1;
      sel(2'h1, LPM_SRC_LSI);
      sel(2'h3, LPM_SRC_LSI);
      sel(2'h2, LPM_SRC_HSE);
      sel(2'h0, LPM_SRC_HSI);
      osc_div_wdata = 2'h0;
      osc_div_wr = 1'b1;
      step(1);
      osc_div_wr = 1'b0;
      check(8'(internal_osc_divider), 8'h00);
      // Wait with interrupt-only operation, then resume main code
      u_cpu.set_al(1'b1);
      u_cpu.issue(0, 0);
      check({6'h0, mode}, 8'(LPM_WAIT));
      check({cpu_clk_en, periph_clk_en, irq_ctrl_clk_en, skip_context}, 8'h07);
      irq_request = 1'b1;
      wait_mode(LPM_RUN, 2, c);
      irq_request = 1'b0;
      check(8'(wake_cause), 8'(LPM_WAKE_IRQ));
      u_cpu.ret(1'b0);
      check(8'(mode), 8'(LPM_WAIT));
      irq_request = 1'b1;
      wait_mode(LPM_RUN, 2, c);
      irq_request = 1'b0;
      check(8'(n_force), 8'h02);
      u_cpu.ret(1'b1);
      step(3);
      check({mode, skip_context}, 8'h00);
      // Active halt; first one cut short, so later wakes are on time only if the timer restarts
      for (int i = 0; i < 3; i++) begin
         {awu_enable, awu_src_lsi, lp_regulator_sel, flash_pd_sel} = {1'b1, i == 2, i == 0, i == 0};
         u_cpu.set_al(1'b1);
         u_cpu.issue(1, i);
         check({mode, skip_context, awu_running, low_power_regulator_on, main_regulator_on, flash_on},
            {LPM_AHALT, 1'b0, 1'b1, i == 0, i != 0, i != 0});
         check({hsi_on, hse_on, lsi_on}, {1'b0, i != 2, i == 2});
         if (i == 0) begin
            step(300);
            halt_periph_irq = 1'b1;
            wait_mode(LPM_RUN, 2, c);
            halt_periph_irq = 1'b0;
            check({awu_running, wake_cause}, {1'b0, LPM_WAKE_PERIPH});
         end else begin
            wait_mode(LPM_RUN, 900, c);
            check(8'(c > LPM_AWU_PRESC_CYC - 6 && c < LPM_AWU_PRESC_CYC + 8), 8'h01);
            check({awu_wakeup, awu_running, wake_cause}, {1'b1, 1'b0, LPM_WAKE_AWU});
            step(1);
            check(8'(n_wake), 8'(i));
         end
      end
      // Full halt, left by a peripheral interrupt and then by the pin
      {awu_enable, flash_on_in_halt} = 2'h0;
      u_cpu.set_al(1'b0);
      u_cpu.issue(1, 0);
      step(20);
      check({mode, hsi_on, hse_on, lsi_on, cpu_clk_en, low_power_regulator_on, main_regulator_on},
         {LPM_HALT, 6'h02});
      check(8'(flash_on), 8'h00);
      halt_periph_irq = 1'b1;
      wait_mode(LPM_RUN, 2, c);
      halt_periph_irq = 1'b0;
      check(8'(wake_cause), 8'(LPM_WAKE_PERIPH));
      flash_on_in_halt = 1'b1;
      u_cpu.issue(1, 0);
      check(8'(flash_on), 8'h01);
      ext_pin_irq = 1'b1;
      wait_mode(LPM_RUN, 6, c);
      ext_pin_irq = 1'b0;
      check(8'(wake_cause), 8'(LPM_WAKE_PIN));
      // Watchdog-forced halt phase never wakes by itself
      independent_watchdog_timer_enabled = 1'b1;
      u_cpu.issue(1, 2);
      check({mode, watchdog_forced_halt, lsi_on, independent_watchdog_timer_clk_en, hsi_on, hse_on},
         {LPM_AHALT, 5'h1c});
      step(2000);
      check(8'(mode), 8'(LPM_AHALT));
      ext_pin_irq = 1'b1;
      wait_mode(LPM_RUN, 6, c);
      ext_pin_irq = 1'b0;
      independent_watchdog_timer_enabled = 1'b0;
      // Reset ends wait and restores the reset state
      u_cpu.issue(0, 0);
      rst_n = 1'b0;
      step(2);
      rst_n = 1'b1;
      check({mode, skip_context, cpu_clk_en, internal_osc_divider}, 8'h07);
      check(8'(wake_cause), 8'(LPM_WAKE_NONE));
      wrap_up();
   end
endmodule
